// ===== common/gain_hpf_pkg.sv
// Shared constants and carrier types for the converter-four correction block.
// Assumes a classic Wishbone slave with 32-bit data and word-aligned registers.
package gain_hpf_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [5:0] IDX_GLOBAL_EN = 6'h03;
  localparam logic [5:0] IDX_PATTERN_MODE = 6'h04;
  localparam logic [5:0] IDX_ODD_GAIN_OFFSET = 6'h13;
  localparam logic [5:0] IDX_EVEN_GAIN_OFFSET = 6'h14;
  localparam logic [5:0] IDX_PATTERN_HPF_CFG = 6'h15;
  localparam logic [5:0] IDX_STATUS = 6'h20;

  // Field positions
  localparam int GAIN_ENABLE_BIT = 12;
  localparam int OFFSET_ENABLE_BIT = 8;
  localparam int PATTERN_SELECT_BIT = 8;
  localparam int GAIN_MSB = 15;
  localparam int GAIN_LSB = 11;
  localparam int OFFSET_MSB = 9;
  localparam int OFFSET_LSB = 0;
  localparam int PRBS_OUT1_BIT = 15;
  localparam int PRBS_OUT4_BIT = 12;
  localparam int PAT1_MSB = 11;
  localparam int PAT1_LSB = 9;
  localparam int PAT2_MSB = 8;
  localparam int PAT2_LSB = 6;
  localparam int ROUND_BIT = 5;
  localparam int CORNER_MSB = 4;
  localparam int CORNER_LSB = 1;
  localparam int HPF_ENABLE_BIT = 0;

  // Reset values
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [23:0] PRBS_SEED = 24'h7FFFFF;

  // Corner limits and arithmetic sizes
  localparam logic [3:0] CORNER_MIN = 4'h2;
  localparam logic [3:0] CORNER_MAX = 4'hA;
  localparam int SAMPLE_W = 14;
  localparam int FRAC_W = 10;
  localparam int GAIN_FRAC_W = 12;
  localparam int NUM_CONV = 4;

  // Pattern codes for outputs one and two
  typedef enum logic [2:0] {
    PAT_NORMAL = 3'h0,
    PAT_ZEROS = 3'h1,
    PAT_ONES = 3'h2,
    PAT_TOGGLE = 3'h3,
    PAT_RAMP = 3'h4
  } pattern_code_t;

  typedef struct packed {
    logic sampleOdd;
    logic [NUM_CONV-1:0][SAMPLE_W-1:0] conv;
  } sample_in_t;

  typedef struct packed {
    logic [NUM_CONV-1:0][SAMPLE_W-1:0] lane;
  } lane_word_t;

endpackage

// ===== verilog/two_entry_buffer.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes source and sink share clk; all outputs come from flip-flops.
`timescale 1ns/10ps
`default_nettype none
module two_entry_buffer #(
  parameter int WIDTH = 56
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Filling side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Draining side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);

  logic [WIDTH-1:0] skidData;
  logic skidValid;
  logic takeIn;

  assign takeIn = inValid & inReady;

  // Output stage and skid entry
  always_ff @(posedge clk) begin
    if (rst) begin
      outValid <= 1'b0;
      skidValid <= 1'b0;
      inReady <= 1'b1;
    end else if (outReady | ~outValid) begin
      if (skidValid) begin
        outValid <= 1'b1;
        skidValid <= takeIn;
        inReady <= ~takeIn;
      end else begin
        outValid <= takeIn;
        skidValid <= 1'b0;
        inReady <= 1'b1;
      end
    end else if (takeIn) begin
      skidValid <= 1'b1;
      inReady <= 1'b0;
    end
  end

  // Data moves with the valid flags
  always_ff @(posedge clk) begin
    if (outReady | ~outValid) begin
      if (skidValid) begin
        outData <= skidData;
        if (takeIn) begin
          skidData <= inData;
        end
      end else if (takeIn) begin
        outData <= inData;
      end
    end else if (takeIn) begin
      skidData <= inData;
    end
  end

endmodule
`default_nettype wire

// ===== verilog/sample_gain_offset_hpf_ctrl.sv
// Gain, offset, high-pass filter and test patterns for four converter lanes.
// Assumes a classic Wishbone master and a sample stream in the clk domain.
//
// Function
// - With gain enabled, odd converter-four samples are scaled by N x 0.2 dB, N from bits 15-11.
// - With gain enabled, even converter-four samples are scaled by N x 0.2 dB from their register.
// - With offset enabled, a 10-bit signed offset (14-bit LSB) is subtracted from odd samples.
// - With offset enabled, a 10-bit signed offset (14-bit LSB) is subtracted from even samples.
// - Gain acts only when index 3 bit 12 is set, offset only when index 3 bit 8 is set.
// - With individual pattern select, each output whose PRBS enable is set carries PRBS.
// - With individual pattern select, outputs one and two carry the coded test patterns.
// - Filter output is truncated to sample width, or rounded when bit 5 is set.
// - The filter corner k comes from bits 4-1, valid from 2 to 10.
// - The filter is bypassed for converters one to four unless bit 0 is set.
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module sample_gain_offset_hpf_ctrl
  import gain_hpf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  // Sample input stream
  input wire logic sampleValid,
  input wire sample_in_t sampleIn,
  output logic sampleReady,
  // Lane output stream
  output logic laneValid,
  output lane_word_t laneOut,
  input wire logic laneReady
);

  // Register state
  logic gain_enable_global;
  logic offset_enable_global;
  logic individual_pattern_select;
  logic [15:0] conv4OddGainOffset;
  logic [15:0] conv4EvenGainOffset;
  logic [15:0] patternHpfCfg;
  logic [15:0] sampleCount;

  // Datapath state
  logic signed [27:0] hpfAcc [NUM_CONV];
  logic signed [27:0] next_hpfAcc [NUM_CONV];
  logic [23:0] prbsState;
  logic [SAMPLE_W-1:0] rampValue;
  logic toggleState;
  lane_word_t next_lanes;
  logic accept;
  logic wbReq;
  logic [5:0] regIdx;

  // Config fields
  logic [4:0] conv4_odd_gain;
  logic [4:0] conv4_even_gain;
  logic [9:0] conv4_odd_offset;
  logic [9:0] conv4_even_offset;
  logic [3:0] prbsEnable;
  logic [2:0] pattern_code_out1;
  logic [2:0] pattern_code_out2;
  logic highpass_round_enable;
  logic [3:0] highpass_corner_k;
  logic highpass_enable_group1;
  logic [3:0] cornerEff;

  assign conv4_odd_gain = conv4OddGainOffset[GAIN_MSB:GAIN_LSB];
  assign conv4_even_gain = conv4EvenGainOffset[GAIN_MSB:GAIN_LSB];
  assign conv4_odd_offset = conv4OddGainOffset[OFFSET_MSB:OFFSET_LSB];
  assign conv4_even_offset = conv4EvenGainOffset[OFFSET_MSB:OFFSET_LSB];
  assign prbsEnable = patternHpfCfg[PRBS_OUT1_BIT:PRBS_OUT4_BIT];
  assign pattern_code_out1 = patternHpfCfg[PAT1_MSB:PAT1_LSB];
  assign pattern_code_out2 = patternHpfCfg[PAT2_MSB:PAT2_LSB];
  assign highpass_round_enable = patternHpfCfg[ROUND_BIT];
  assign highpass_corner_k = patternHpfCfg[CORNER_MSB:CORNER_LSB];
  assign highpass_enable_group1 = patternHpfCfg[HPF_ENABLE_BIT];

  // Out-of-range k clamps to the valid span
  assign cornerEff = (highpass_corner_k < CORNER_MIN) ? CORNER_MIN :
                     (highpass_corner_k > CORNER_MAX) ? CORNER_MAX :
                     highpass_corner_k;

  assign accept = sampleValid & sampleReady;
  assign wbReq = wbCyc & wbStb & ~wbAck;
  assign regIdx = wbAdr[7:2];

  // Gain of N x 0.2 dB as a linear factor, 12 fraction bits
  function automatic logic [13:0] gain_factor(input logic [4:0] n);
    logic [13:0] f;
    f = 14'h1000;
    case (n)
      5'd0: f = 14'd4096;
      5'd1: f = 14'd4191;
      5'd2: f = 14'd4289;
      5'd3: f = 14'd4389;
      5'd4: f = 14'd4491;
      5'd5: f = 14'd4596;
      5'd6: f = 14'd4703;
      5'd7: f = 14'd4812;
      5'd8: f = 14'd4924;
      5'd9: f = 14'd5039;
      5'd10: f = 14'd5157;
      5'd11: f = 14'd5277;
      5'd12: f = 14'd5400;
      5'd13: f = 14'd5525;
      5'd14: f = 14'd5654;
      5'd15: f = 14'd5786;
      5'd16: f = 14'd5921;
      5'd17: f = 14'd6058;
      5'd18: f = 14'd6200;
      5'd19: f = 14'd6344;
      5'd20: f = 14'd6492;
      5'd21: f = 14'd6643;
      5'd22: f = 14'd6798;
      5'd23: f = 14'd6956;
      5'd24: f = 14'd7118;
      5'd25: f = 14'd7284;
      5'd26: f = 14'd7453;
      5'd27: f = 14'd7627;
      5'd28: f = 14'd7805;
      5'd29: f = 14'd7986;
      5'd30: f = 14'd8173;
      5'd31: f = 14'd8363;
      default: f = 14'h1000;
    endcase
    return f;
  endfunction

  // Clip a wide signed value to the sample range
  function automatic logic signed [13:0] sat14(input logic signed [27:0] v);
    logic signed [13:0] r;
    r = v[13:0];
    if (v > 28'sd8191) begin
      r = 14'sh1FFF;
    end else if (v < -28'sd8192) begin
      r = 14'sh2000;
    end
    return r;
  endfunction

  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = d[7:0];
    end
    if (sel[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // Register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      gain_enable_global <= 1'b0;
      offset_enable_global <= 1'b0;
      individual_pattern_select <= 1'b0;
      conv4OddGainOffset <= CFG_RESET;
      conv4EvenGainOffset <= CFG_RESET;
      patternHpfCfg <= CFG_RESET;
    end else if (wbReq & wbWe) begin
      case (regIdx)
        IDX_GLOBAL_EN: begin
          if (wbSel[1]) begin
            gain_enable_global <= wbDatI[GAIN_ENABLE_BIT];
            offset_enable_global <= wbDatI[OFFSET_ENABLE_BIT];
          end
        end
        IDX_PATTERN_MODE: begin
          if (wbSel[1]) begin
            individual_pattern_select <= wbDatI[PATTERN_SELECT_BIT];
          end
        end
        IDX_ODD_GAIN_OFFSET: conv4OddGainOffset <= merge16(conv4OddGainOffset, wbDatI, wbSel);
        IDX_EVEN_GAIN_OFFSET: conv4EvenGainOffset <= merge16(conv4EvenGainOffset, wbDatI, wbSel);
        IDX_PATTERN_HPF_CFG: patternHpfCfg <= merge16(patternHpfCfg, wbDatI, wbSel);
        default: begin
        end
      endcase
    end
  end

  // Bus answer, one wait state
  always_ff @(posedge clk) begin
    if (rst) begin
      wbAck <= 1'b0;
      wbDatO <= 32'h0000_0000;
    end else begin
      wbAck <= wbReq;
      wbDatO <= 32'h0000_0000;
      if (wbReq & ~wbWe) begin
        case (regIdx)
          IDX_GLOBAL_EN: begin
            wbDatO[GAIN_ENABLE_BIT] <= gain_enable_global;
            wbDatO[OFFSET_ENABLE_BIT] <= offset_enable_global;
          end
          IDX_PATTERN_MODE: wbDatO[PATTERN_SELECT_BIT] <= individual_pattern_select;
          IDX_ODD_GAIN_OFFSET: wbDatO[15:0] <= conv4OddGainOffset;
          IDX_EVEN_GAIN_OFFSET: wbDatO[15:0] <= conv4EvenGainOffset;
          IDX_PATTERN_HPF_CFG: wbDatO[15:0] <= patternHpfCfg;
          IDX_STATUS: wbDatO[17:0] <= {laneValid, sampleReady, sampleCount};
          default: wbDatO <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Correction, filter and pattern selection
  always_comb begin
    logic signed [27:0] x;
    logic signed [42:0] prod;
    logic signed [27:0] err;
    logic signed [27:0] y;
    logic [4:0] gainN;
    logic [9:0] offs;
    logic [SAMPLE_W-1:0] lane;
    x = 28'sd0;
    prod = 43'sd0;
    err = 28'sd0;
    y = 28'sd0;
    gainN = 5'd0;
    offs = 10'd0;
    lane = '0;
    for (int i = 0; i < NUM_CONV; i++) begin
      x = 28'(signed'(sampleIn.conv[i]));
      if (i == NUM_CONV - 1) begin
        offs = sampleIn.sampleOdd ? conv4_odd_offset : conv4_even_offset;
        gainN = sampleIn.sampleOdd ? conv4_odd_gain : conv4_even_gain;
        if (offset_enable_global) begin
          x = x - 28'(signed'(offs));
        end
        if (gain_enable_global) begin
          prod = 43'(x) * 43'(signed'({1'b0, gain_factor(gainN)}));
          x = 28'(prod >>> GAIN_FRAC_W);
        end
        x = 28'(sat14(x));
      end
      err = (x <<< FRAC_W) - hpfAcc[i];
      next_hpfAcc[i] = hpfAcc[i];
      if (highpass_enable_group1) begin
        if (highpass_round_enable) begin
          y = (err + 28'sd512) >>> FRAC_W;
        end else begin
          y = err >>> FRAC_W;
        end
        next_hpfAcc[i] = hpfAcc[i] + (err >>> cornerEff);
      end else begin
        y = x;
        next_hpfAcc[i] = 28'sd0;
      end
      lane = sat14(y);
      if (individual_pattern_select & (i < 2)) begin
        case (pattern_code_t'((i == 0) ? pattern_code_out1 : pattern_code_out2))
          PAT_ZEROS: lane = 14'h0000;
          PAT_ONES: lane = 14'h3FFF;
          PAT_TOGGLE: lane = toggleState ? 14'h2AAA : 14'h1555;
          PAT_RAMP: lane = rampValue;
          default: lane = sat14(y);
        endcase
      end
      if (individual_pattern_select & prbsEnable[NUM_CONV - 1 - i]) begin
        lane = prbsState[SAMPLE_W-1:0];
      end
      next_lanes.lane[i] = lane;
    end
  end

  // Filter accumulators advance on each accepted beat
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_CONV; i++) begin
        hpfAcc[i] <= 28'sd0;
      end
    end else if (accept) begin
      for (int i = 0; i < NUM_CONV; i++) begin
        hpfAcc[i] <= next_hpfAcc[i];
      end
    end
  end

  // Pattern generators, PRBS x^23 + x^18 + 1
  always_ff @(posedge clk) begin
    if (rst) begin
      prbsState <= PRBS_SEED;
      rampValue <= 14'h0000;
      toggleState <= 1'b0;
    end else if (accept) begin
      prbsState <= {prbsState[22:0], prbsState[22] ^ prbsState[17]};
      rampValue <= rampValue + 14'h0001;
      toggleState <= ~toggleState;
    end
  end

  // Accepted sample count
  always_ff @(posedge clk) begin
    if (rst) begin
      sampleCount <= 16'h0000;
    end else if (accept) begin
      sampleCount <= sampleCount + 16'h0001;
    end
  end

  two_entry_buffer #(
    .WIDTH($bits(lane_word_t))
  ) laneBuffer (
    .clk(clk),
    .rst(rst),
    .inValid(sampleValid),
    .inData(next_lanes),
    .inReady(sampleReady),
    .outValid(laneValid),
    .outData(laneOut),
    .outReady(laneReady)
  );

endmodule
`default_nettype wire

// ===== test/sample_gain_offset_hpf_ctrl_assertions.sv
// Port checker for the correction block.
// Assumes a bind to the top module; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module sample_gain_offset_hpf_ctrl_checker
  import gain_hpf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  input wire logic [31:0] wbDatO,
  input wire logic wbAck,
  // Streams
  input wire logic sampleValid,
  input wire sample_in_t sampleIn,
  input wire logic sampleReady,
  input wire logic laneValid,
  input wire lane_word_t laneOut,
  input wire logic laneReady
);
  logic mapped;
  assign mapped = wbAdr[7:2] inside {6'h03, 6'h04, 6'h13, 6'h14, 6'h15, 6'h20};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  ack_latency_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
    else $error("ack late");
  ack_pulse_a: assert property (wbAck |=> !wbAck) else $error("ack too long");
  rdata_idle_a: assert property (!wbAck |-> wbDatO == 32'h0) else $error("data outside ack");
  unmapped_zero_a: assert property (wbAck && !wbWe && !mapped |-> wbDatO == 32'h0)
    else $error("unmapped read not zero");
  lane_hold_a: assert property (laneValid && !laneReady |=> laneValid && $stable(laneOut))
    else $error("lane word dropped");
  first_word_a: assert property (sampleValid && sampleReady && !laneValid |=> laneValid)
    else $error("lane word late");
  full_cause_a: assert property ($fell(sampleReady) |-> $past(laneValid && !laneReady))
    else $error("refused without stall");
  drain_resume_a: assert property (!sampleReady && laneReady |=> sampleReady)
    else $error("no resume after drain");
  cover property (wbAck && wbWe);
  cover property (wbAck && !wbWe && !mapped);
  cover property (!sampleReady);
endmodule
bind sample_gain_offset_hpf_ctrl sample_gain_offset_hpf_ctrl_checker
  i_sample_gain_offset_hpf_ctrl_checker (.clk, .rst, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel,
  .wbDatI, .wbDatO, .wbAck, .sampleValid, .sampleIn, .sampleReady, .laneValid, .laneOut,
  .laneReady);
`default_nettype wire

// ===== test/lane_sink.sv
// Host receiver model for the four output lanes.
// Assumes valid/ready words in the clk domain.
`timescale 1ns/10ps
`default_nettype none
module lane_sink
  import gain_hpf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Stall modes
  input wire logic hold,
  input wire logic slow,
  // Lanes
  input wire logic laneValid,
  input wire lane_word_t laneOut,
  output logic laneReady
);
  // Ready, held off or random when slow
  always_ff @(posedge clk) begin
    if (rst) begin
      laneReady <= 1'b1;
    end else begin
      laneReady <= !hold && (!slow || $urandom_range(1) == 1);
    end
  end
endmodule
`default_nettype wire

// ===== test/tb_sample_gain_offset_hpf_ctrl.sv
// Self-checking bench for the correction block.
// Assumes package, block, lane sink and checker compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_sample_gain_offset_hpf_ctrl
  import gain_hpf_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatI = 32'h0, wbDatO;
  logic wbAck, sampleReady, laneValid, laneReady, sampleValid = 1'b0, hold = 1'b0, slow = 1'b0;
  sample_in_t sampleIn = '0;
  lane_word_t laneOut;
  logic [15:0] mir [64] = '{default: 16'h0};
  logic [5:0] regs [3] = '{IDX_ODD_GAIN_OFFSET, IDX_EVEN_GAIN_OFFSET, IDX_PATTERN_HPF_CFG};
  logic [4:0] gains [4] = '{5'h00, 5'h01, 5'h0F, 5'h1F};
  logic [3:0] ks [6] = '{4'h2, 4'hA, 4'h5, 4'h0, 4'hF, 4'h3};
  logic [15:0] d;
  int acc [4] = '{default: 0};
  logic [23:0] prbs = PRBS_SEED;
  int beats = 0;
  int fail_count = 0, n_compared = 0;
  logic [31:0] regQ [$];
  lane_word_t laneQ [$];

  always #50 clk = ~clk;

  sample_gain_offset_hpf_ctrl i_sample_gain_offset_hpf_ctrl (.clk, .rst, .wbCyc, .wbStb, .wbWe,
    .wbAdr, .wbSel, .wbDatI, .wbDatO, .wbAck, .sampleValid, .sampleIn, .sampleReady, .laneValid,
    .laneOut, .laneReady);
  lane_sink i_lane_sink (.clk, .rst, .hold, .slow, .laneValid, .laneOut, .laneReady);

  task automatic chk(input string what, input logic [55:0] exp, input logic [55:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wb(input logic we, input logic [5:0] idx, input logic [15:0] v);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {idx, 2'h0};
    wbSel <= 4'h3;
    wbDatI <= {16'h0, v};
    do @(posedge clk); while (wbAck !== 1'b1);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [15:0] v);
    wb(1'b1, idx, v);
    mir[idx] = v;
  endtask

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
    regQ.push_back(exp);
    wb(1'b0, idx, 16'h0);
  endtask

  function automatic int clip(input int v);
    return v > 8191 ? 8191 : (v < -8192 ? -8192 : v);
  endfunction

  // Notes the expected word, then offers the beat until taken
  task automatic send(input sample_in_t s);
    lane_word_t w;
    int x, e, k;
    logic [15:0] g, cfg;
    logic [2:0] c;
    cfg = mir[IDX_PATTERN_HPF_CFG];
    g = s.sampleOdd ? mir[IDX_ODD_GAIN_OFFSET] : mir[IDX_EVEN_GAIN_OFFSET];
    for (int i = 0; i < 4; i++) begin
      x = $signed(s.conv[i]);
      if (i == 3 && mir[IDX_GLOBAL_EN][8]) begin
        x -= $signed(g[9:0]);
      end
      if (i == 3 && mir[IDX_GLOBAL_EN][12]) begin
        x = (x * int'(4096.0 * 10.0 ** (g[15:11] * 0.01))) >>> 12;
      end
      x = clip(x);
      if (cfg[0]) begin
        k = cfg[4:1] < 2 ? 2 : (cfg[4:1] > 10 ? 10 : cfg[4:1]);
        e = x * 1024 - acc[i];
        x = clip(cfg[5] ? (e + 512) >>> 10 : e >>> 10);
        acc[i] += e >>> k;
      end else begin
        acc[i] = 0;
      end
      w.lane[i] = x[13:0];
    end
    for (int j = 0; j < 2; j++) begin
      c = j ? cfg[8:6] : cfg[11:9];
      if (mir[IDX_PATTERN_MODE][8] && c == 3'h1) w.lane[j] = 14'h0000;
      if (mir[IDX_PATTERN_MODE][8] && c == 3'h2) w.lane[j] = 14'h3FFF;
      if (mir[IDX_PATTERN_MODE][8] && c == 3'h3) begin
        w.lane[j] = beats[0] ? 14'h2AAA : 14'h1555;
      end
      if (mir[IDX_PATTERN_MODE][8] && c == 3'h4) w.lane[j] = 14'(beats);
    end
    // PRBS x^23 + x^18 + 1 overrides the coded pattern
    for (int j = 0; j < 4; j++) begin
      if (mir[IDX_PATTERN_MODE][8] && cfg[15 - j]) w.lane[j] = prbs[13:0];
    end
    prbs = {prbs[22:0], prbs[22] ^ prbs[17]};
    beats++;
    laneQ.push_back(w);
    sampleIn <= s;
    sampleValid <= 1'b1;
    do @(posedge clk); while (sampleReady !== 1'b1);
  endtask

  task automatic burst(input int n);
    repeat (n) send(sample_in_t'(57'({$urandom, $urandom})));
    sampleValid <= 1'b0;
    @(posedge clk);
  endtask

  always @(posedge clk) begin
    if (wbAck === 1'b1 && wbWe === 1'b0) begin
      chk("register", regQ.size() > 0 ? regQ.pop_front() : 'x, wbDatO);
    end
    if (laneValid === 1'b1 && laneReady === 1'b1) begin
      chk("lane", laneQ.size() > 0 ? laneQ.pop_front() : 'x, laneOut);
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results;
  end

  initial begin
    void'($urandom(93807));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (regs[i]) rd(regs[i], 32'h0);
    foreach (regs[i]) begin
      d = 16'($urandom) & 16'hFBFF;
      wr(regs[i], d);
      rd(regs[i], {16'h0, d});
    end
    wr(6'h3F, 16'hFFFF);
    rd(6'h3F, 32'h0);
    $display("test registers done");
    wr(IDX_PATTERN_HPF_CFG, 16'h0000);
    burst(8);
    slow <= 1'b1;
    wr(IDX_GLOBAL_EN, 16'h1100);
    rd(IDX_GLOBAL_EN, 32'h0000_1100);
    foreach (gains[i]) begin
      wr(IDX_ODD_GAIN_OFFSET, {gains[i], 1'b0, 10'($urandom)});
      wr(IDX_EVEN_GAIN_OFFSET, 16'($urandom) & 16'hFBFF);
      burst(6);
    end
    wr(IDX_GLOBAL_EN, 16'h0100);
    burst(4);
    wr(IDX_GLOBAL_EN, 16'h1000);
    burst(4);
    $display("test gain and offset done");
    foreach (ks[i]) begin
      wr(IDX_PATTERN_HPF_CFG, {10'h000, i[0], ks[i], 1'b1});
      burst(6);
    end
    $display("test highpass done");
    wr(IDX_PATTERN_MODE, 16'h0100);
    rd(IDX_PATTERN_MODE, 32'h0000_0100);
    for (int c = 0; c < 8; c++) begin
      wr(IDX_PATTERN_HPF_CFG, {4'(c * 13), 3'(c), 3'(7 - c), 6'h00});
      burst(3);
    end
    wr(IDX_PATTERN_MODE, 16'h0000);
    burst(3);
    $display("test patterns done");
    hold <= 1'b1;
    fork
      begin
        repeat (12) @(posedge clk);
        hold <= 1'b0;
      end
    join_none
    burst(6);
    repeat (30) @(posedge clk);
    rd(IDX_STATUS, {14'h0, 2'b01, 16'(beats)});
    chk("pending", 56'h0, 56'(laneQ.size()));
    $display("test stall done");
    results;
  end
endmodule
`default_nettype wire
